// ==== src/bfs_top.sv ====
// Buck fault supervisor: phase control, current limit, fault restart, irq.
// Assumes comparator inputs are asynchronous; APB master on pclk.
// Behaviour
// - High-side delay bit delays top switch turn-on 6 cycles, about 120ns.
// - Edge bit selects rising or falling clock edge for turn-on.
// - Peak limit reached turns switch off for rest of cycle.
// - 75% limit for 16 cycles sets near-limit flag and interrupt.
// - Full limit for 16 cycles drives the interrupt.
// - 122.5% peak shuts rail at once, retries after 14ms.
// - Unmasked short enters system fault, all off, restart after 100ms.
// - Out of regulation over 28us after soft-start folds limit to 1.5A.
// - Overcurrent and short events latch flags until read.
// - Overcurrent mask suppresses interrupt and system fault reporting.
// - Bypass keeps low-side off; pass switch uses delay and soft-start.
// - Bypass overcurrent flag follows pass-switch current detector.
// - Bypass undervoltage flag follows 5.6A shutdown, system fault.
// - Bypass disables overvoltage detection for rail one.
// - LDO soft-start lasts fixed 275us on enable and after system faults.
// - Power-good interrupt holds until rail off or good, and read.
`timescale 1ns/1ns
module bfs_top #(
	parameter int RESTART_CYCLES = bfs_pkg::RESTART_CYC,
	parameter int SYS_CYCLES = bfs_pkg::SYS_RESTART_CYC,
	parameter int LDO_SS_CYCLES = bfs_pkg::LDO_SS_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sw_clk,
	input wire logic [2:0] rail_en,
	input wire logic [2:0] cmp_warn,
	input wire logic [2:0] cmp_lim,
	input wire logic [2:0] cmp_short,
	input wire logic [2:0] out_of_reg,
	input wire logic [2:0] ss_done,
	input wire logic [2:0] pok_in,
	input wire logic ov_in,
	input wire logic [1:0] ldo_en_in,
	output logic [2:0] hs_on,
	output logic [2:0] ls_on,
	output logic [2:0] rail_on,
	output logic [2:0] foldback,
	output logic [1:0] ldo_ss,
	output logic fault_irq_n
);
	localparam int W = bfs_pkg::ST_W;
	// Two-flop synchronisers for all analog and pin inputs
	logic [21:0] s1, s2;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1 <= '0;
			s2 <= '0;
		end else begin
			s1 <= {ldo_en_in, ov_in, pok_in, ss_done, out_of_reg, cmp_short,
				cmp_lim, cmp_warn, sw_clk};
			s2 <= s1;
		end
	end
	logic clk_s, ov_s;
	logic [2:0] warn_s, lim_s, short_s, oor_s, ssd_s, pok_s;
	logic [1:0] ldoen_s;
	assign {ldoen_s, ov_s, pok_s, ssd_s, oor_s, short_s, lim_s, warn_s,
		clk_s} = s2;
	// Rail enables are pins too, so they pass two flops as well
	logic [2:0] en_m, en_s;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_m <= '0;
			en_s <= '0;
		end else begin
			en_m <= rail_en;
			en_s <= en_m;
		end
	end

	// Registers
	logic [31:0] ctrl;
	logic [W-1:0] mask, stat;
	bfs_pkg::bfs_state_t state;
	logic bypass;
	assign bypass = ctrl[bfs_pkg::CTRL_BYPASS];
	logic wr, rd;
	assign wr = psel && penable && pwrite;
	assign rd = psel && penable && !pwrite;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= bfs_pkg::CTRL_RST;
			mask <= bfs_pkg::MASK_RST;
		end else if (wr && paddr == bfs_pkg::ADDR_CTRL) begin
			ctrl <= pwdata;
		end else if (wr && paddr == bfs_pkg::ADDR_MASK) begin
			mask <= pwdata[W-1:0];
		end
	end

	// Switching clock edge detect; selected edge starts a cycle
	logic clk_d;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_d <= 1'b0;
		end else begin
			clk_d <= clk_s;
		end
	end
	logic cyc_start;
	assign cyc_start = ctrl[bfs_pkg::CTRL_EDGE] ? (clk_d && !clk_s) :
		(!clk_d && clk_s);

	// Turn-on delay counter; latency of the synchroniser adds ~40ns
	logic [3:0] dly;
	logic [2:0] cut;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dly <= '0;
		end else if (cyc_start) begin
			dly <= ctrl[bfs_pkg::CTRL_HSDLY] ?
				4'(bfs_pkg::HS_DELAY_CYC) : 4'h0;
		end else if (dly != 4'h0) begin
			dly <= dly - 4'h1;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cut <= '0;
		end else if (cyc_start) begin
			cut <= '0;
		end else begin
			cut <= cut | lim_s;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hs_on <= '0;
			ls_on <= '0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				hs_on[i] <= rail_on[i] && dly == 4'h0 && !cut[i] &&
					!lim_s[i];
				ls_on[i] <= rail_on[i] && !(i == 0 && bypass) &&
					!(dly == 4'h0 && !cut[i] && !lim_s[i]);
			end
		end
	end

	// Per-cycle run counters for warn and limit
	logic [4:0] wcnt [3];
	logic [4:0] lcnt [3];
	logic [2:0] wseen, lseen, warn_ev, lim_ev;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wseen <= '0;
			lseen <= '0;
			warn_ev <= '0;
			lim_ev <= '0;
			for (int i = 0; i < 3; i++) begin
				wcnt[i] <= '0;
				lcnt[i] <= '0;
			end
		end else begin
			warn_ev <= '0;
			lim_ev <= '0;
			if (cyc_start) begin
				wseen <= '0;
				lseen <= '0;
				for (int i = 0; i < 3; i++) begin
					wcnt[i] <= wseen[i] ? wcnt[i] + 5'h1 : 5'h0;
					lcnt[i] <= lseen[i] ? lcnt[i] + 5'h1 : 5'h0;
					warn_ev[i] <= wseen[i] &&
						wcnt[i] == 5'(bfs_pkg::OC_RUN - 1);
					lim_ev[i] <= lseen[i] &&
						lcnt[i] == 5'(bfs_pkg::OC_RUN - 1);
				end
			end else begin
				wseen <= wseen | warn_s;
				lseen <= lseen | lim_s;
			end
		end
	end

	// Short circuit: rail off, 14ms retry; unmasked goes system-wide
	logic [22:0] rcnt [3];
	logic [2:0] rail_off;
	logic [22:0] scnt;
	logic [2:0] short_ev;
	logic byp_trip, sys_trip;
	assign short_ev = short_s & rail_on;
	assign byp_trip = bypass && rail_on[0] && short_s[0];
	assign sys_trip = |(short_ev & ~mask[bfs_pkg::ST_OC +: 3]) ||
		(byp_trip && !mask[bfs_pkg::ST_UV]);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= bfs_pkg::BFS_RUN;
			scnt <= '0;
		end else begin
			unique case (state)
				bfs_pkg::BFS_RUN: begin
					if (sys_trip) begin
						state <= bfs_pkg::BFS_SYSFLT;
						scnt <= 23'(SYS_CYCLES - 1);
					end
				end
				bfs_pkg::BFS_SYSFLT, bfs_pkg::BFS_OFF: begin
					if (scnt == '0) begin
						state <= bfs_pkg::BFS_RUN;
					end else begin
						scnt <= scnt - 23'h1;
					end
				end
			endcase
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rail_off <= '0;
			for (int i = 0; i < 3; i++) begin
				rcnt[i] <= '0;
			end
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (short_ev[i]) begin
					rail_off[i] <= 1'b1;
					rcnt[i] <= 23'(RESTART_CYCLES - 1);
				end else if (rail_off[i]) begin
					if (rcnt[i] == '0) begin
						rail_off[i] <= 1'b0;
					end else begin
						rcnt[i] <= rcnt[i] - 23'h1;
					end
				end
			end
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rail_on <= '0;
		end else begin
			rail_on <= (state == bfs_pkg::BFS_RUN && !sys_trip) ?
				en_s & ~rail_off & ~short_ev : 3'h0;
		end
	end

	// Foldback after 28us out of regulation
	logic [10:0] fcnt [3];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			foldback <= '0;
			for (int i = 0; i < 3; i++) begin
				fcnt[i] <= '0;
			end
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (!ssd_s[i] || !oor_s[i] || !rail_on[i]) begin
					fcnt[i] <= '0;
					foldback[i] <= 1'b0;
				end else if (fcnt[i] == 11'(bfs_pkg::FOLD_CYC)) begin
					foldback[i] <= 1'b1;
				end else begin
					fcnt[i] <= fcnt[i] + 11'h1;
				end
			end
		end
	end

	// LDO soft-start timers restart on enable and after system fault
	logic [13:0] lss [2];
	logic [1:0] ldo_prev;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ldo_ss <= '0;
			ldo_prev <= '0;
			for (int i = 0; i < 2; i++) begin
				lss[i] <= '0;
			end
		end else begin
			for (int i = 0; i < 2; i++) begin
				ldo_prev[i] <= ldoen_s[i] && state == bfs_pkg::BFS_RUN;
				if (!(ldoen_s[i] && state == bfs_pkg::BFS_RUN)) begin
					ldo_ss[i] <= 1'b0;
				end else if (!ldo_prev[i]) begin
					lss[i] <= 14'(LDO_SS_CYCLES - 1);
					ldo_ss[i] <= 1'b1;
				end else if (lss[i] != '0) begin
					lss[i] <= lss[i] - 14'h1;
				end else begin
					ldo_ss[i] <= 1'b0;
				end
			end
		end
	end

	// Sticky status, read clears; set wins over clear
	logic [W-1:0] set_ev, live;
	logic [2:0] pok_bad;
	always_comb begin
		pok_bad = rail_on & ssd_s & ~pok_s;
		set_ev = '0;
		set_ev[bfs_pkg::ST_WARN +: 3] = warn_ev;
		set_ev[bfs_pkg::ST_OC +: 3] = lim_ev | short_ev;
		if (bypass) begin
			set_ev[bfs_pkg::ST_OC] = lim_s[0] && rail_on[0];
			set_ev[bfs_pkg::ST_UV] = byp_trip;
		end
		set_ev[bfs_pkg::ST_POK +: 3] = pok_bad;
		set_ev[bfs_pkg::ST_OV] = ov_s && !bypass;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat <= '0;
		end else if (rd && paddr == bfs_pkg::ADDR_STAT) begin
			stat <= set_ev | pok_bad_hold(stat, pok_bad);
		end else begin
			stat <= stat | set_ev;
		end
	end
	// Power-good bits survive a read while the rail is still out of spec
	function automatic logic [W-1:0] pok_bad_hold(input logic [W-1:0] s,
		input logic [2:0] bad);
		logic [W-1:0] r;
		r = '0;
		r[bfs_pkg::ST_POK +: 3] = s[bfs_pkg::ST_POK +: 3] & bad;
		return r;
	endfunction : pok_bad_hold
	assign live = {2'b00, ov_s && !bypass, pok_s, 3'b000, lim_s, warn_s};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_irq_n <= 1'b1;
		end else begin
			fault_irq_n <= !(|(stat & ~mask));
		end
	end

	// APB answers in the access cycle; no wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			prdata <= '0;
			if (psel && !penable) begin
				unique case (paddr)
					bfs_pkg::ADDR_CTRL: prdata <= ctrl;
					bfs_pkg::ADDR_MASK: prdata <= {17'h0, mask};
					bfs_pkg::ADDR_STAT: prdata <= {17'h0, stat | set_ev};
					bfs_pkg::ADDR_LIVE: prdata <= {17'h0, live};
					bfs_pkg::ADDR_LDOEN: prdata <= {30'h0, ldo_ss};
					default: pslverr <= 1'b1;
				endcase
			end
		end
	end
endmodule : bfs_top

// ==== src/bfs_pkg.sv ====
// Shared constants for the buck fault supervisor.
// Assumes a 50 MHz pclk and APB register access.
package bfs_pkg;
	localparam int CLK_MHZ = 50;
	localparam int CLK_NS = 1000 / CLK_MHZ;
	localparam int NRAIL = 3;
	localparam int NLDO = 2;
	localparam int HS_DELAY_NS = 110;
	localparam int HS_DELAY_CYC = (HS_DELAY_NS + CLK_NS - 1) / CLK_NS;
	localparam int RESTART_MS = 14;
	localparam int RESTART_CYC = RESTART_MS * 1000 * CLK_MHZ * 1000 / 1000;
	localparam int SYS_RESTART_MS = 100;
	localparam int SYS_RESTART_CYC = SYS_RESTART_MS * 1000 * CLK_MHZ;
	localparam int FOLD_US = 28;
	localparam int FOLD_CYC = FOLD_US * CLK_MHZ;
	localparam int LDO_SS_US = 275;
	localparam int LDO_SS_CYC = LDO_SS_US * CLK_MHZ;
	localparam int OC_RUN = 16;
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_MASK = 12'h004;
	localparam logic [11:0] ADDR_STAT = 12'h008;
	localparam logic [11:0] ADDR_LIVE = 12'h00C;
	localparam logic [11:0] ADDR_LDOEN = 12'h010;
	// CTRL fields
	localparam int CTRL_HSDLY = 0;
	localparam int CTRL_EDGE = 1;
	localparam int CTRL_BYPASS = 2;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	// STAT/MASK fields, 3 bits each (one per rail; UV and OV use only their low bit)
	localparam int ST_WARN = 0;
	localparam int ST_OC = 3;
	localparam int ST_UV = 6;
	localparam int ST_POK = 9;
	localparam int ST_OV = 12;
	localparam int ST_W = 15;
	localparam logic [14:0] MASK_RST = 15'h7FFF;
	typedef enum logic [1:0] {BFS_RUN, BFS_OFF, BFS_SYSFLT} bfs_state_t;
endpackage : bfs_pkg

// ==== dv/bfs_monitor.sv ====
// Checker for bfs_top, bound below.
// Assumes APB writes land at the access edge.
`timescale 1ns/1ns
module bfs_monitor (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic [2:0] cmp_short,
	input wire logic [2:0] out_of_reg,
	input wire logic [2:0] ls_on,
	input wire logic [2:0] rail_on,
	input wire logic [2:0] foldback,
	input wire logic fault_irq_n
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic byp, oc_open, all_mask;
	// Register state is not at the ports, so shadow it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			byp <= 1'b0;
			oc_open <= 1'b0;
			all_mask <= 1'b1;
		end else if (psel && penable && pready && pwrite) begin
			if (paddr == bfs_pkg::ADDR_CTRL)
				byp <= pwdata[bfs_pkg::CTRL_BYPASS];
			if (paddr == bfs_pkg::ADDR_MASK)
				oc_open <= !pwdata[bfs_pkg::ST_OC + 2];
			if (paddr == bfs_pkg::ADDR_MASK)
				all_mask <= &pwdata[14:0];
		end
	end
	sequence s_short; $rose(cmp_short[2]); endsequence
	sequence s_in_reg; !out_of_reg[0] [*8]; endsequence
	property p_off; s_short |-> ##[1:30] !rail_on[2]; endproperty
	a_off: assert property (p_off) else $error("rail on");
	property p_sys; oc_open ##0 s_short |-> ##[1:30] rail_on == 3'h0;
	endproperty
	a_sys: assert property (p_sys) else $error("rails on");
	property p_hold; $fell(rail_on[2]) |=> !rail_on[2] [*8]; endproperty
	a_hold: assert property (p_hold) else $error("fast retry");
	property p_fold; $rose(foldback[0]) |-> $past(out_of_reg[0], 4);
	endproperty
	a_fold: assert property (p_fold) else $error("fold");
	property p_unfold; s_in_reg |-> !foldback[0]; endproperty
	a_unfold: assert property (p_unfold) else $error("unfold");
	property p_byp; byp [*3] |-> !ls_on[0]; endproperty
	a_byp: assert property (p_byp) else $error("low side");
	property p_mask; all_mask [*2] |-> fault_irq_n; endproperty
	a_mask: assert property (p_mask) else $error("irq");
	property p_ans; psel && !penable |=> pready; endproperty
	a_ans: assert property (p_ans) else $error("no ready");
endmodule : bfs_monitor
bind bfs_top bfs_monitor u_mon (.*);

// ==== dv/bfs_host.sv ====
// Host model: APB master for the system processor.
// Assumes tasks start just after a rising pclk edge.
`timescale 1ns/1ns
module bfs_host (
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial begin
		{psel, penable, pwrite} = 3'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
	end
	// Request held until pready is seen; idle edge after avoids re-entry
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (!pready);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : xfer
endmodule : bfs_host

// ==== dv/tb_bfs_top.sv ====
// Bench for bfs_top, one task per scenario.
// Assumes short restart counts set by parameters.
`timescale 1ns/1ns
module tb_bfs_top;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic sw_clk = 1'b0;
	logic ov_in = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, fault_irq_n, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [2:0] rail_en = 3'h7, pok_in = 3'h7, ss_done = 3'h7;
	logic [2:0] cmp_warn = 3'h0, cmp_lim = 3'h0, cmp_short = 3'h0;
	logic [2:0] out_of_reg = 3'h0, hs_on, ls_on, rail_on, foldback;
	logic [1:0] ldo_en_in = 2'h0, ldo_ss;
	int checks = 0, bad_count = 0, cyc = 0;
	bfs_top #(.RESTART_CYCLES(50), .SYS_CYCLES(100), .LDO_SS_CYCLES(20))
		u_dut (.*);
	bfs_host u_host (.*);
	always #10 pclk = ~pclk;
	// Slow switching clock keeps on-time above the minimum
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc % 5 == 4)
			sw_clk <= ~sw_clk;
		if (cyc == 20000) begin
			bad_count++;
			results();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: %h vs %h", $time, got, exp);
		end
	endtask : chk
	task automatic results();
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : results
	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
	endtask : wt
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		u_host.xfer(1'b1, a, d, q, e);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		u_host.xfer(1'b0, a, 32'h0, q, e);
		chk(q, x);
	endtask : rd
	task automatic irq(input logic x);
		chk(32'(fault_irq_n), 32'(x));
	endtask : irq
	task automatic t_warn();
		wr(bfs_pkg::ADDR_MASK, 32'h0);
		cmp_warn <= 3'h2;
		wt(130);
		irq(1'b1);
		wt(100);
		irq(1'b0);
		cmp_warn <= 3'h0;
		wt(4);
		rd(bfs_pkg::ADDR_STAT, 32'h2 << bfs_pkg::ST_WARN);
		wt(2);
		irq(1'b1);
		rd(bfs_pkg::ADDR_STAT, 32'h0);
	endtask : t_warn
	task automatic t_short(input logic [31:0] m);
		wr(bfs_pkg::ADDR_MASK, m);
		cmp_short <= 3'h4;
		wt(20);
		cmp_short <= 3'h0;
		chk(32'(rail_on), m[5] ? 32'h3 : 32'h0);
		irq(m[5]);
		wt(140);
		chk(32'(rail_on), 32'h7);
		wr(bfs_pkg::ADDR_MASK, 32'h7FFF);
		wt(2);
		irq(1'b1);
		rd(bfs_pkg::ADDR_STAT, 32'h4 << bfs_pkg::ST_OC);
	endtask : t_short
	task automatic t_fold();
		out_of_reg <= 3'h1;
		wt(1300);
		chk(32'(foldback), 32'h0);
		wt(200);
		chk(32'(foldback), 32'h1);
		out_of_reg <= 3'h0;
		wt(10);
		chk(32'(foldback), 32'h0);
	endtask : t_fold
	task automatic t_phase();
		wr(bfs_pkg::ADDR_CTRL, 32'h1);
		@(posedge sw_clk);
		wt(6);
		chk(32'(hs_on[0]), 32'h0);
		chk(32'(ls_on[0]), 32'h1);
		wr(bfs_pkg::ADDR_CTRL, 32'h0);
		@(posedge sw_clk);
		wt(6);
		chk(32'(hs_on[0]), 32'h1);
		wr(bfs_pkg::ADDR_CTRL, 32'h3);
		@(posedge sw_clk);
		wt(6);
		chk(32'(hs_on[0]), 32'h1);
		@(negedge sw_clk);
		wt(6);
		chk(32'(hs_on[0]), 32'h0);
		wr(bfs_pkg::ADDR_CTRL, 32'h0);
	endtask : t_phase
	task automatic t_lim();
		wr(bfs_pkg::ADDR_MASK, 32'h0);
		cmp_lim <= 3'h1;
		wt(4);
		chk(32'(hs_on[0]), 32'h0);
		wt(200);
		irq(1'b0);
		cmp_lim <= 3'h0;
		wt(4);
		rd(bfs_pkg::ADDR_STAT, 32'h1 << bfs_pkg::ST_OC);
	endtask : t_lim
	task automatic t_pok();
		pok_in <= 3'h6;
		wt(5);
		irq(1'b0);
		rd(bfs_pkg::ADDR_STAT, 32'h1 << bfs_pkg::ST_POK);
		rd(bfs_pkg::ADDR_STAT, 32'h1 << bfs_pkg::ST_POK);
		pok_in <= 3'h7;
		wt(4);
		rd(bfs_pkg::ADDR_STAT, 32'h1 << bfs_pkg::ST_POK);
		wt(2);
		irq(1'b1);
	endtask : t_pok
	task automatic t_ldo();
		ldo_en_in <= 2'h1;
		wt(5);
		chk(32'(ldo_ss), 32'h1);
		rd(bfs_pkg::ADDR_LDOEN, 32'h1);
		wt(25);
		chk(32'(ldo_ss), 32'h0);
	endtask : t_ldo
	task automatic t_byp();
		wr(bfs_pkg::ADDR_CTRL, 32'h4);
		rd(bfs_pkg::ADDR_CTRL, 32'h4);
		wt(3);
		chk(32'(ls_on[0]), 32'h0);
		wr(bfs_pkg::ADDR_MASK, 32'h0);
		ov_in <= 1'b1;
		wt(10);
		irq(1'b1);
		cmp_short <= 3'h1;
		wt(20);
		cmp_short <= 3'h0;
		chk(32'(rail_on), 32'h0);
		wt(140);
		rd(bfs_pkg::ADDR_STAT, 32'h1 << bfs_pkg::ST_UV);
	endtask : t_byp
	initial begin
		wt(8);
		presetn <= 1'b1;
		wt(1);
		rd(bfs_pkg::ADDR_MASK, 32'(bfs_pkg::MASK_RST));
		rd(12'h020, 32'h0);
		chk(32'(e), 32'h1);
		t_warn();
		t_short(32'h7FFF);
		t_short(32'h7FDF);
		t_fold();
		t_phase();
		t_lim();
		t_pok();
		t_ldo();
		t_byp();
		results();
	end
endmodule : tb_bfs_top
